// ---- ast_pkg.sv ----
/*
 * Package for the asynchronous serial transceiver: register map, field
 * positions, reset values and timing constants.
 * Assumes a 32-bit APB slave with each byte register in one aligned word.
 */
package ast_pkg;

	// ------------------------------------------------------------
	// register byte addresses
	// ------------------------------------------------------------
	localparam logic [7:0] AST_RCSTA_ADDR = 8'h00;
	localparam logic [7:0] AST_TXBUF_ADDR = 8'h04;
	localparam logic [7:0] AST_TXSTA_ADDR = 8'h08;
	localparam logic [7:0] AST_BAUD_ADDR  = 8'h0C;
	localparam logic [7:0] AST_DIVH_ADDR  = 8'h10;
	localparam logic [7:0] AST_DIVL_ADDR  = 8'h14;
	localparam logic [7:0] AST_RXBUF_ADDR = 8'h18;
	localparam logic [7:0] AST_IRQ_ADDR   = 8'h1C;

	// ------------------------------------------------------------
	// receive_status_control fields
	// ------------------------------------------------------------
	localparam int AST_RC_SERIAL_PORT_ENABLE  = 7;
	localparam int AST_RC_RX9   = 6;
	localparam int AST_RC_CONTINUOUS_RECEIVE_ENABLE  = 4;
	localparam int AST_RC_ADDRESS_DETECT_ENABLE = 3;
	localparam int AST_RC_FRAMING_ERROR  = 2;
	localparam int AST_RC_OVERRUN_ERROR  = 1;
	localparam int AST_RC_RX_NINTH_BIT_VALUE  = 0;

	// ------------------------------------------------------------
	// transmit_status_control fields
	// ------------------------------------------------------------
	localparam int AST_TX_TX9   = 6;
	localparam int AST_TX_TRANSMIT_ENABLE  = 5;
	localparam int AST_TX_SYNC  = 4;
	localparam int AST_TX_HIGH_SPEED_BAUD  = 2;
	localparam int AST_TX_SHIFTER_EMPTY  = 1;
	localparam int AST_TX_TX_NINTH_BIT_VALUE  = 0;

	// ------------------------------------------------------------
	// baud_control fields
	// ------------------------------------------------------------
	localparam int AST_BC_RCIDL = 6;
	localparam int AST_BC_RXINV = 5;
	localparam int AST_BC_TXINV = 4;
	localparam int AST_BC_WIDE_BAUD_COUNTER = 3;

	// ------------------------------------------------------------
	// interrupt flag / enable register fields
	// ------------------------------------------------------------
	localparam int AST_IR_TXIF = 0;
	localparam int AST_IR_RCIF = 1;
	localparam int AST_IR_TXIE = 2;
	localparam int AST_IR_RCIE = 3;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0] AST_TXSTA_RST = 8'h02;
	localparam logic [7:0] AST_RCSTA_RST = 8'h00;
	localparam logic [7:0] AST_BAUD_RST  = 8'h00;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int AST_OVS       = 16;
	localparam int AST_OVS_W     = 4;
	localparam int AST_SAMPLE_AT = 7;
	localparam int AST_INSTR_CLK = 4;

endpackage

// ---- ast_remote_dev.sv ----
/* remote serial device: sends frames on request, decodes frames seen.
   assumes a fixed bit time of BIT system clocks. */
`timescale 1ns/1ps
module ast_remote_dev #(
	parameter int BIT = 32
) (
	input  wire logic       clk_i,
	input  wire logic       line_i,
	input  wire logic       nine_i,
	output logic            line_o,
	output logic            got_o,
	output logic [9:0]      word_o
);
	logic [9:0] w;
	int         k;
	initial begin
		line_o = 1'b1;
		got_o  = 1'b0;
		word_o = 10'h000;
	end
	// stop level is a parameter so a broken frame can be sent
	task automatic send(input logic [8:0] d, input logic nb,
			input logic stop);
		@(posedge clk_i);
		line_o <= 1'b0;
		for (int i = 0; i < (nb ? 9 : 8); i++) begin
			repeat (BIT) @(posedge clk_i);
			line_o <= d[i];
		end
		repeat (BIT) @(posedge clk_i);
		line_o <= stop;
		repeat (BIT) @(posedge clk_i);
		line_o <= 1'b1;
		repeat (2) @(posedge clk_i);
	endtask
	// a start shorter than half a bit is a glitch, not a frame
	always begin
		@(posedge clk_i);
		if (line_i === 1'b0) begin
			repeat (BIT / 2) @(posedge clk_i);
			if (line_i === 1'b0) begin
				w = 10'h000;
				k = nine_i ? 9 : 8;
				for (int i = 0; i < k; i++) begin
					repeat (BIT) @(posedge clk_i);
					w[i] = line_i;
				end
				repeat (BIT) @(posedge clk_i);
				w[9] = line_i;
				got_o  <= 1'b1;
				word_o <= w;
				@(posedge clk_i);
				got_o  <= 1'b0;
			end
		end
	end
endmodule

// ---- ast_rx_fifo.sv ----
/*
 * Two-deep receive holding store for ten-bit words; read data come
 * out of a register.
 * A write while full and a read while empty are ignored.
 */
`timescale 1ns/1ps
module ast_rx_fifo #(
	parameter int W     = 10,
	parameter int DEPTH = 2
) (
	input  wire logic         clk_sys_i,
	input  wire logic         sys_rst_i,
	input  wire logic         flush_i,
	input  wire logic         wr_i,
	input  wire logic [W-1:0] wdata_i,
	input  wire logic         rd_i,
	output logic      [W-1:0] rdata_o,
	output logic              empty_o,
	output logic              full_o
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem_q [DEPTH];
	logic [AW:0]  cnt_q;
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	wire          do_wr = wr_i && !full_o;
	wire          do_rd = rd_i && !empty_o;
	wire [AW-1:0] rp_n  = (int'(rp_q) == DEPTH - 1) ? '0 : rp_q + 1'b1;
	wire [AW-1:0] wp_n  = (int'(wp_q) == DEPTH - 1) ? '0 : wp_q + 1'b1;
	wire [AW-1:0] rsel  = do_rd ? rp_n : rp_q;

	assign empty_o = (cnt_q == '0);
	assign full_o  = (int'(cnt_q) == DEPTH);

	always_ff @(posedge clk_sys_i) begin
		if (do_wr)
			mem_q[wp_q] <= wdata_i;
	end

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cnt_q <= '0;
			wp_q  <= '0;
			rp_q  <= '0;
		end else if (flush_i) begin
			cnt_q <= '0;
			wp_q  <= '0;
			rp_q  <= '0;
		end else begin
			if (do_wr)
				wp_q <= wp_n;
			if (do_rd)
				rp_q <= rp_n;
			cnt_q <= cnt_q + (AW+1)'(do_wr) - (AW+1)'(do_rd);
		end
	end

	// head word always registered; a write into an empty store shows next cycle
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			rdata_o <= '0;
		else if (do_wr && (empty_o || (cnt_q == 1 && do_rd)))
			rdata_o <= wdata_i;
		else
			rdata_o <= mem_q[rsel];
	end
endmodule

// ---- ast_top.sv ----
/*
 * Asynchronous serial transceiver: APB register slave, shared baud
 * generator, transmit buffer and shifter, oversampling receiver with a
 * two-character store, 9-bit address detection and pin polarity control.
 * Assumes APB signals and the receive pin synchronous to clk_sys_i.
 */
`timescale 1ns/1ps
module ast_top
	import ast_pkg::*;
#(
	parameter int RX_DEPTH = 2
) (
	input  wire logic        clk_sys_i,
	input  wire logic        sys_rst_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	input  wire logic        rx_pin_i,
	output logic             tx_pin_o,
	output logic             irq_o
);
	typedef enum logic [1:0] {
		AST_S_IDLE  = 2'b00,
		AST_S_START = 2'b01,
		AST_S_DATA  = 2'b11,
		AST_S_STOP  = 2'b10
	} ast_state_t;

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [7:0]  rc_q, tx_q, bc_q, divh_q, divl_q;
	logic [7:0]  txbuf_q;
	logic        txbuf_full_q, txif_q, txie_q, rcie_q;
	logic        framing_error_vis_q, overrun_error_q;

	wire         serial_port_enable   = rc_q[AST_RC_SERIAL_PORT_ENABLE];
	wire         continuous_receive_enable   = rc_q[AST_RC_CONTINUOUS_RECEIVE_ENABLE];
	wire         address_detect_enable  = rc_q[AST_RC_ADDRESS_DETECT_ENABLE];
	wire         rx9    = rc_q[AST_RC_RX9];
	wire         transmit_enable   = tx_q[AST_TX_TRANSMIT_ENABLE];
	wire         tx9    = tx_q[AST_TX_TX9];
	wire         high_speed_baud   = tx_q[AST_TX_HIGH_SPEED_BAUD];
	wire         wide_baud_counter  = bc_q[AST_BC_WIDE_BAUD_COUNTER];
	wire         async_md = serial_port_enable && !tx_q[AST_TX_SYNC];

	// ------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------
	wire         acc     = psel_i && penable_i && pready_o;
	wire         wr      = acc && pwrite_i;
	wire         rd      = acc && !pwrite_i;
	wire         known   = (paddr_i[1:0] == 2'b00) && (paddr_i <= AST_IRQ_ADDR);
	wire         wr_rc   = wr && paddr_i == AST_RCSTA_ADDR;
	wire         wr_txb  = wr && paddr_i == AST_TXBUF_ADDR;
	wire         wr_tx   = wr && paddr_i == AST_TXSTA_ADDR;
	wire         wr_bc   = wr && paddr_i == AST_BAUD_ADDR;
	wire         wr_dh   = wr && paddr_i == AST_DIVH_ADDR;
	wire         wr_dl   = wr && paddr_i == AST_DIVL_ADDR;
	wire         wr_ir   = wr && paddr_i == AST_IRQ_ADDR;
	wire         rd_rxb  = rd && paddr_i == AST_RXBUF_ADDR;
	wire [7:0]   wb      = pwdata_i[7:0];

	// ------------------------------------------------------------
	// baud generator: one tick per 1/16 bit for both directions
	// ------------------------------------------------------------
	logic [15:0] brg_q;
	logic [1:0]  pre_q;
	logic        tick_q;
	wire  [15:0] div     = wide_baud_counter ? {divh_q, divl_q} : {8'h00, divl_q};
	wire         brg_hit = (brg_q == 16'h0000);
	// x64 mode needs four brg periods per 16x tick; x16 mode ticks each period
	// either rate bit on selects x16; both off selects x64
	wire         x64     = !high_speed_baud && !wide_baud_counter;
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			brg_q  <= 16'h0000;
			pre_q  <= 2'b00;
			tick_q <= 1'b0;
		end else begin
			brg_q  <= (!async_md || brg_hit) ? div : brg_q - 16'h0001;
			if (async_md && brg_hit)
				pre_q <= pre_q + 2'b01;
			tick_q <= async_md && brg_hit && (!x64 || pre_q == 2'b11);
		end
	end

	// ------------------------------------------------------------
	// transmitter
	// ------------------------------------------------------------
	ast_state_t  ts_q;
	logic [8:0]  tsr_q;
	logic [3:0]  tbit_q;
	logic [AST_OVS_W-1:0] tph_q;
	logic        tline_q;
	logic [2:0]  wr_dly_q;
	wire         tx_go   = async_md && transmit_enable;
	wire         tlast   = tick_q && tph_q == 4'(AST_OVS - 1);
	wire         tnbits  = tbit_q == (tx9 ? 4'd8 : 4'd7);
	wire         load    = tx_go && ts_q == AST_S_IDLE && txbuf_full_q;
	wire         transmit_enable_up = wr_tx && wb[AST_TX_TRANSMIT_ENABLE] && !transmit_enable;
	// a fresh write is not taken by the shifter until its flag has dropped
	wire         wr_hold = |wr_dly_q;

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ts_q    <= AST_S_IDLE;
			tsr_q   <= 9'h000;
			tbit_q  <= 4'h0;
			tph_q   <= '0;
			tline_q <= 1'b1;
		end else if (!tx_go) begin
			ts_q    <= AST_S_IDLE;
			tline_q <= 1'b1;
		end else begin
			unique case (ts_q)
			AST_S_IDLE: begin
				if (load && !wr_hold) begin
					tsr_q <= {tx_q[AST_TX_TX_NINTH_BIT_VALUE], txbuf_q};
					ts_q  <= AST_S_START;
					tph_q <= '0;
				end
			end
			AST_S_START: begin
				tline_q <= 1'b0;
				if (tlast) begin
					ts_q   <= AST_S_DATA;
					tbit_q <= 4'h0;
				end
			end
			AST_S_DATA: begin
				tline_q <= tsr_q[0];
				if (tlast) begin
					tsr_q  <= {1'b0, tsr_q[8:1]};
					tbit_q <= tbit_q + 4'h1;
					if (tnbits)
						ts_q <= AST_S_STOP;
				end
			end
			AST_S_STOP: begin
				tline_q <= 1'b1;
				if (tlast)
					ts_q <= AST_S_IDLE;
			end
			endcase
			if (tick_q && ts_q != AST_S_IDLE)
				tph_q <= tph_q + 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			txbuf_q      <= 8'h00;
			txbuf_full_q <= 1'b0;
			txif_q       <= 1'b0;
			wr_dly_q     <= 3'b000;
		end else begin
			wr_dly_q <= {wr_dly_q[1:0], wr_txb};
			if (wr_txb) begin
				txbuf_q      <= wb;
				txbuf_full_q <= 1'b1;
			end else if (load && !wr_hold)
				txbuf_full_q <= 1'b0;
			if (load && !wr_hold || transmit_enable_up)
				txif_q <= 1'b1;
			else if (wr_dly_q[0])
				txif_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// receiver
	// ------------------------------------------------------------
	ast_state_t  rs_q;
	logic [8:0]  rsh_q;
	logic [3:0]  rbit_q;
	logic [AST_OVS_W-1:0] rph_q;
	logic [2:0]  smp_q;
	logic        ff_wr_q;
	logic [9:0]  ff_wd_q;
	wire  [9:0]  ff_rd;
	wire         ff_empty, ff_full;
	wire         rx_go   = async_md && continuous_receive_enable;
	wire         rx_in   = rx_pin_i ^ bc_q[AST_BC_RXINV];
	wire         vote    = (smp_q[0] & smp_q[1]) | (smp_q[1] & smp_q[2]) |
	                       (smp_q[0] & smp_q[2]);
	wire         rmid    = tick_q && rph_q == 4'(AST_SAMPLE_AT + 1);
	wire         rnbits  = rbit_q == (rx9 ? 4'd8 : 4'd7);
	wire  [8:0]  rword   = rx9 ? rsh_q : {1'b0, rsh_q[8:1]};
	wire         keep    = !(address_detect_enable && rx9) || rword[8];
	wire         stop_ok = vote;

	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rs_q    <= AST_S_IDLE;
			rsh_q   <= 9'h000;
			rbit_q  <= 4'h0;
			rph_q   <= '0;
			smp_q   <= 3'b111;
			ff_wr_q <= 1'b0;
			ff_wd_q <= 10'h000;
			framing_error_vis_q <= 1'b0;
			overrun_error_q  <= 1'b0;
		end else if (!rx_go) begin
			rs_q    <= AST_S_IDLE;
			ff_wr_q <= 1'b0;
			framing_error_vis_q <= 1'b0;
			overrun_error_q  <= 1'b0;
		end else begin
			ff_wr_q <= 1'b0;
			if (tick_q) begin
				smp_q <= {smp_q[1:0], rx_in};
				rph_q <= rph_q + 1'b1;
			end
			unique case (rs_q)
			AST_S_IDLE: begin
				// start needs a falling edge, so a low stop bit or a held
				// low line cannot retrigger a frame
				if (tick_q && !rx_in && smp_q[0] && !overrun_error_q) begin
					rs_q  <= AST_S_START;
					rph_q <= '0;
				end
			end
			AST_S_START: begin
				if (rmid) begin
					rs_q   <= vote ? AST_S_IDLE : AST_S_DATA;
					rbit_q <= 4'h0;
				end
			end
			AST_S_DATA: begin
				if (rmid) begin
					rsh_q  <= {vote, rsh_q[8:1]};
					rbit_q <= rbit_q + 4'h1;
					if (rnbits)
						rs_q <= AST_S_STOP;
				end
			end
			AST_S_STOP: begin
				if (rmid) begin
					rs_q <= AST_S_IDLE;
					if (keep) begin
						if (ff_full)
							overrun_error_q <= 1'b1;
						else begin
							ff_wr_q <= 1'b1;
							ff_wd_q <= {!stop_ok, rword};
						end
					end
				end
			end
			endcase
			// limitation: a fresh character also re-shows older stored errors
			if (ff_wr_q)
				framing_error_vis_q <= 1'b1;
		end
	end

	ast_rx_fifo #(
		.W     (10),
		.DEPTH (RX_DEPTH)
	) u_rx_fifo (
		.clk_sys_i (clk_sys_i),
		.sys_rst_i (sys_rst_i),
		.flush_i   (!serial_port_enable),
		.wr_i      (ff_wr_q),
		.wdata_i   (ff_wd_q),
		.rd_i      (rd_rxb),
		.rdata_o   (ff_rd),
		.empty_o   (ff_empty),
		.full_o    (ff_full)
	);

	// ------------------------------------------------------------
	// register writes and read mux
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rc_q   <= AST_RCSTA_RST;
			tx_q   <= AST_TXSTA_RST;
			bc_q   <= AST_BAUD_RST;
			divh_q <= 8'h00;
			divl_q <= 8'h00;
			txie_q <= 1'b0;
			rcie_q <= 1'b0;
		end else begin
			if (wr_rc)
				rc_q <= wb & 8'hD8;
			if (wr_tx)
				tx_q <= wb & 8'h75;
			if (wr_bc)
				bc_q <= wb & 8'h38;
			if (wr_dh)
				divh_q <= wb;
			if (wr_dl)
				divl_q <= wb;
			if (wr_ir) begin
				txie_q <= wb[AST_IR_TXIE];
				rcie_q <= wb[AST_IR_RCIE];
			end
		end
	end

	wire        rcif  = !ff_empty;
	wire        shifter_empty  = ts_q == AST_S_IDLE;
	wire [7:0]  rc_rd = {rc_q[7:3], ff_rd[9] & !ff_empty & framing_error_vis_q, overrun_error_q,
	                     ff_rd[8] & rx9};
	wire [7:0]  tx_rd = {tx_q[7:2], shifter_empty, tx_q[0]};
	wire [7:0]  bc_rd = {bc_q[7], rs_q == AST_S_IDLE, bc_q[5:0]};
	wire [7:0]  ir_rd = {4'h0, rcie_q, txie_q, rcif, txif_q};
	logic [7:0] rmux;
	always_comb begin
		unique case (paddr_i)
		AST_RCSTA_ADDR: rmux = rc_rd;
		AST_TXBUF_ADDR: rmux = txbuf_q;
		AST_TXSTA_ADDR: rmux = tx_rd;
		AST_BAUD_ADDR:  rmux = bc_rd;
		AST_DIVH_ADDR:  rmux = divh_q;
		AST_DIVL_ADDR:  rmux = divl_q;
		AST_RXBUF_ADDR: rmux = ff_rd[7:0];
		AST_IRQ_ADDR:   rmux = ir_rd;
		default:        rmux = 8'h00;
		endcase
	end

	// ------------------------------------------------------------
	// outputs, all registered; pready rises one cycle into access
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			prdata_o  <= 32'h0000_0000;
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
			tx_pin_o  <= 1'b1;
			irq_o     <= 1'b0;
		end else begin
			pready_o  <= psel_i && penable_i && !pready_o;
			pslverr_o <= psel_i && penable_i && !pready_o && !known;
			prdata_o  <= {24'h00_0000, rmux};
			tx_pin_o  <= tline_q ^ bc_q[AST_BC_TXINV];
			irq_o     <= (txif_q && txie_q) || (rcif && rcie_q);
		end
	end
endmodule

// ---- ast_top_properties.sv ----
/* bus timing and pin level checks for ast_top.
   assumes it is bound onto the ports of ast_top. */
`timescale 1ns/1ps
module ast_top_properties
	import ast_pkg::*;
#(
	parameter int RX_DEPTH = 2
) (
	input wire logic        clk_sys_i,
	input wire logic        sys_rst_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [7:0]  paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic        pready_o,
	input wire logic        pslverr_o,
	input wire logic        rx_pin_i,
	input wire logic        tx_pin_o,
	input wire logic        irq_o
);
	wire bad_addr;
	assign bad_addr = (paddr_i > AST_IRQ_ADDR) || (paddr_i[1:0] != 2'b00);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);
	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	a_ready_one_wait:
		assert property (psel_i && penable_i && !$past(penable_i)
			|-> !pready_o ##1 pready_o)
		else $error("answer not after one wait state");
	a_ready_single:
		assert property (pready_o |=> !pready_o)
		else $error("ready longer than one cycle");
	a_ready_in_access:
		assert property (pready_o |-> psel_i && penable_i)
		else $error("ready outside an access");
	a_err_with_ready:
		assert property (pslverr_o |-> pready_o)
		else $error("error without ready");
	a_err_unmapped:
		assert property (pready_o && bad_addr |-> pslverr_o)
		else $error("unmapped access not refused");
	a_ok_mapped:
		assert property (pready_o && !bad_addr |-> !pslverr_o)
		else $error("mapped access refused");
	a_err_read_zero:
		assert property (pready_o && pslverr_o && !pwrite_i
			|-> prdata_o == 32'h0000_0000)
		else $error("refused read returned data");
	a_upper_lanes_zero:
		assert property (pready_o |-> prdata_o[31:8] == 24'h00_0000)
		else $error("read data above byte lane");
	a_tx_idle_reset:
		assert property ($fell(sys_rst_i) |-> tx_pin_o && !irq_o)
		else $error("line not idle after reset");
	c_write: cover property (pready_o && pwrite_i && !pslverr_o);
	c_read: cover property (pready_o && !pwrite_i && !pslverr_o);
	c_refused: cover property (pslverr_o);
endmodule
bind ast_top ast_top_properties #(.RX_DEPTH(RX_DEPTH)) u_props (
	.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
	.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
	.pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
	.pslverr_o(pslverr_o), .rx_pin_i(rx_pin_i), .tx_pin_o(tx_pin_o),
	.irq_o(irq_o));

// ---- test_async_serial_transceiver.sv ----
/* self-checking bench for ast_top with a remote serial device.
   assumes ast_pkg register map and one-wait-state bus answers. */
`timescale 1ns/1ps
module test_async_serial_transceiver;
	import ast_pkg::*;
	localparam int          BIT = 32;
	localparam logic [32:0] ALL = 33'h1_ffff_ffff;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic        pready, pslverr, tx, irq, dtx, got;
	logic        nine = 1'b0;
	logic        inv = 1'b0;
	logic [9:0]  word;
	logic [32:0] exp_rd[$], msk_rd[$], exp_tx[$];
	logic [31:0] seed = 32'he9b9_9b7e;
	int          miscompares = 0;
	int          checks_done = 0;

	always #20 clk = ~clk;

	ast_top dut (.clk_sys_i(clk), .sys_rst_i(rst), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .rx_pin_i(dtx ^ inv), .tx_pin_o(tx),
		.irq_o(irq));
	ast_remote_dev #(.BIT(BIT)) u_dev (.clk_i(clk), .line_i(tx ^ inv),
		.nine_i(nine), .line_o(dtx), .got_o(got), .word_o(word));

	function automatic logic [7:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed[7:0];
	endfunction
	task automatic check(input string n, input logic [32:0] s,
			input logic [32:0] e);
		checks_done++;
		if (s !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic test_done();
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// ------------------------------------------------------------
	// bus and serial helpers
	// ------------------------------------------------------------
	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		// no cycle budget here: only the watchdog may end a stuck access
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [32:0] e,
			input logic [32:0] m);
		exp_rd.push_back(e & m);
		msk_rd.push_back(m);
		apb(1'b0, a, 32'h0000_0000);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h00_0000, d});
	endtask
	task automatic tx_byte(input logic [8:0] d);
		exp_tx.push_back({23'h00_0000, 1'b1, d});
		wr(AST_TXBUF_ADDR, d[7:0]);
	endtask
	task automatic wait_tx();
		int n;
		n = 0;
		while (exp_tx.size() != 0 && n < 2000) begin
			@(posedge clk);
			n++;
		end
		check("tx drained", 33'(exp_tx.size()), 33'h0);
		repeat (BIT) @(posedge clk);
	endtask
	task automatic rx(input logic [8:0] d, input logic nb, input logic s);
		u_dev.send(d, nb, s);
		repeat (4) @(posedge clk);
	endtask

	always @(posedge clk) begin
		if (pready === 1'b1 && pwrite === 1'b0 && exp_rd.size() > 0) begin
			check("read", {pslverr, prdata} & msk_rd[0],
				exp_rd.pop_front());
			void'(msk_rd.pop_front());
		end
		if (got === 1'b1)
			check("frame", {23'h00_0000, word}, exp_tx.pop_front());
	end

	initial begin
		repeat (40000) @(posedge clk);
		miscompares++;
		test_done();
	end

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	initial begin
		logic [7:0] b, c0, c1;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		rd(AST_TXSTA_ADDR, {25'h0, AST_TXSTA_RST}, ALL);
		rd(AST_RCSTA_ADDR, {25'h0, AST_RCSTA_RST}, ALL);
		rd(AST_BAUD_ADDR, {25'h0, AST_BAUD_RST}, ALL & ~33'h40);
		rd(8'h20, 33'h1_0000_0000, ALL);
		rd(8'h06, 33'h1_0000_0000, ALL);
		wr(AST_DIVL_ADDR, 8'h01);
		wr(AST_DIVH_ADDR, rnd());
		wr(AST_IRQ_ADDR, 8'h08);
		wr(AST_TXSTA_ADDR, 8'h24);
		rd(AST_IRQ_ADDR, 33'h1, 33'h1_0000_0001);
		check("irq masked", irq, 1'b0);
		wr(AST_RCSTA_ADDR, 8'h90);
		for (int i = 0; i < 2; i++)
			tx_byte({1'b0, rnd()});
		rd(AST_TXSTA_ADDR, 33'h0, 33'h1_0000_0002);
		wait_tx();
		rd(AST_TXSTA_ADDR, 33'h2, 33'h1_0000_0002);
		nine <= 1'b1;
		wr(AST_TXSTA_ADDR, 8'h65);
		tx_byte({1'b1, rnd()});
		wait_tx();
		nine <= 1'b0;
		wr(AST_TXSTA_ADDR, 8'h24);
		b = rnd();
		rx({1'b0, b}, 1'b0, 1'b1);
		check("irq rx", irq, 1'b1);
		rd(AST_RCSTA_ADDR, 33'h90, 33'h1_0000_00fe);
		rd(AST_RXBUF_ADDR, {25'h0, b}, ALL);
		repeat (2) @(posedge clk);
		check("irq clear", irq, 1'b0);
		c0 = rnd();
		c1 = rnd();
		rx({1'b0, c0}, 1'b0, 1'b1);
		rx({1'b0, c1}, 1'b0, 1'b1);
		rx({1'b0, rnd()}, 1'b0, 1'b1);
		rd(AST_RCSTA_ADDR, 33'h2, 33'h1_0000_0002);
		wr(AST_RCSTA_ADDR, 8'h80);
		rd(AST_RCSTA_ADDR, 33'h0, 33'h1_0000_0006);
		rd(AST_RXBUF_ADDR, {25'h0, c0}, ALL);
		rd(AST_RXBUF_ADDR, {25'h0, c1}, ALL);
		wr(AST_RCSTA_ADDR, 8'h90);
		b = rnd();
		rx({1'b0, b}, 1'b0, 1'b0);
		rd(AST_RCSTA_ADDR, 33'h4, 33'h1_0000_0004);
		wr(AST_RCSTA_ADDR, 8'h80);
		rd(AST_RCSTA_ADDR, 33'h0, 33'h1_0000_0004);
		rd(AST_RXBUF_ADDR, {25'h0, b}, ALL);
		wr(AST_RCSTA_ADDR, 8'hd8);
		rx({1'b0, rnd()}, 1'b1, 1'b1);
		rd(AST_IRQ_ADDR, 33'h0, 33'h1_0000_0002);
		b = rnd();
		rx({1'b1, b}, 1'b1, 1'b1);
		rd(AST_RCSTA_ADDR, 33'h1, 33'h1_0000_0001);
		rd(AST_RXBUF_ADDR, {25'h0, b}, ALL);
		wr(AST_RCSTA_ADDR, 8'h80);
		wr(AST_DIVH_ADDR, 8'h00);
		wr(AST_BAUD_ADDR, 8'h38);
		inv <= 1'b1;
		wr(AST_RCSTA_ADDR, 8'h90);
		b = rnd();
		rx({1'b0, b}, 1'b0, 1'b1);
		rd(AST_RXBUF_ADDR, {25'h0, b}, ALL);
		tx_byte({1'b0, rnd()});
		wait_tx();
		wr(AST_IRQ_ADDR, 8'h0c);
		repeat (2) @(posedge clk);
		check("irq tx", irq, 1'b1);
		test_done();
	end
endmodule
